/* common/fpks_pkg.sv */
package fpks_pkg;

  // register port
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam logic [7:0]  OFS_CMD      = 8'h00;
  localparam logic [7:0]  OFS_DATA     = 8'h04;
  localparam logic [7:0]  OFS_IR_CTRL  = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_CLEAR    = 8'h10;
  localparam logic [7:0]  OFS_ENABLE   = 8'h14;
  localparam logic [7:0]  OFS_LIVE     = 8'h18;
  localparam logic [7:0]  OFS_STATE    = 8'h1C;

  // commands
  localparam logic [7:0]  CMD_READ_RAM = 8'h60;
  localparam logic [7:0]  CMD_CLR_IRQ  = 8'hE0;

  // emitter control values
  localparam logic [7:0]  IR_OFF_VAL   = 8'h00;
  localparam logic [7:0]  IR_ON_VAL    = 8'h01;

  // sensor layout
  localparam int unsigned KEY_N        = 10;
  localparam int unsigned ROW_N        = 22;
  localparam int unsigned RAM_BYTES    = 8;
  localparam int unsigned RAM_W        = RAM_BYTES * 8;
  localparam int unsigned PTR_W        = 4;
  localparam int unsigned KEY_POS      = 0;
  localparam int unsigned ROW_POS      = 16;

  // hard key bit positions
  localparam int unsigned KEY_RUN_STOP = 0;
  localparam int unsigned KEY_AUTOSET  = 1;
  localparam int unsigned KEY_HARDCOPY = 2;
  localparam int unsigned KEY_ENH_ACC  = 3;
  localparam int unsigned KEY_WAVEFORM = 4;
  localparam int unsigned KEY_TRIGGER  = 5;
  localparam int unsigned KEY_MEASURE  = 6;
  localparam int unsigned KEY_STORE    = 7;
  localparam int unsigned KEY_UTILITY  = 8;
  localparam int unsigned KEY_TOUCH    = 9;

  // event bits
  localparam int unsigned EVT_N        = 3;
  localparam int unsigned EVT_CHANGE   = 0;
  localparam int unsigned EVT_DUMP     = 1;
  localparam int unsigned EVT_BAD_CMD  = 2;

  // emitter line reset value and priming cycle count
  localparam logic        IR_DIS_N_RST = 1'b1;
  localparam logic [1:0]  PRIME_CYC    = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DUMP = 2'b10
  } fpks_state_t;

endpackage

/* core/fpks_sync.sv */
module fpks_sync
  import fpks_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] hold_reg;
  logic [W-1:0] hold_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = d_i;
    hold_next = meta_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      hold_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      hold_reg <= hold_next;
    end
  end

  assign q_o = hold_reg;

endmodule // fpks_sync

/* core/fpks_evt.sv */
module fpks_evt
  import fpks_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [EVT_N-1:0] evt_i,
  input  wire logic             clr_wr_i,
  input  wire logic             en_wr_i,
  input  wire logic [EVT_N-1:0] wdata_i,
  output logic      [EVT_N-1:0] status_o,
  output logic      [EVT_N-1:0] enable_o,
  output logic                  irq_o
);

  logic [EVT_N-1:0] status_reg;
  logic [EVT_N-1:0] status_next;
  logic [EVT_N-1:0] enable_reg;
  logic [EVT_N-1:0] enable_next;

  always_comb begin
    status_next = status_reg;
    enable_next = enable_reg;
    if (clr_wr_i) begin
      status_next = status_reg & ~wdata_i;
    end
    // a new event beats a clear in the same cycle
    status_next = status_next | evt_i;
    if (en_wr_i) begin
      enable_next = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= '0;
      enable_reg <= '0;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  assign status_o = status_reg;
  assign enable_o = enable_reg;
  assign irq_o    = |(status_reg & enable_reg);

endmodule // fpks_evt

/* core/fpks_top.sv */
// Operation
// - writing 00 to emitter control drives disable line low, emitters off
// - writing 01 to emitter control drives disable line high, emitters on
// - command 60h makes eight following data reads return RAM bytes
// - command E0h clears the pending front panel interrupt
// - request output feeds interrupt input 4, low when none pending
// - any change of sensor RAM contents raises a front panel interrupt
// - ten hard key bits, 1 while key open, 0 while closed
// - key bits 0..9 are run/stop through touch panel on/off, in order
// - twenty-two infrared row receptor states are reflected in sensor RAM
// - row bit reads 1 when its emitter is not sensed, 0 when sensed
//
// The register offsets and the address-and-strobe port were decided locally.
module fpks_top
  import fpks_pkg::*;
(
  input  wire logic              MCLK_I,
  input  wire logic              RSTN_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [DATA_W-1:0] RDATA_O,
  input  wire logic [KEY_N-1:0]  HARD_KEY_OPEN_I,
  input  wire logic [ROW_N-1:0]  ROW_UNSENSED_I,
  output logic                   INFRARED_EMITTER_DISABLE_N_O,
  output logic                   FRONT_PANEL_REQUEST_INPUT_O,
  output logic                   IRQ_O
);

  // synchronised sensor pins
  logic [KEY_N-1:0] key_sync;
  logic [ROW_N-1:0] row_sync;

  // live sensor RAM image
  logic [RAM_W-1:0] ram_live;

  // change detection
  logic [RAM_W-1:0] ram_prev_reg;
  logic [RAM_W-1:0] ram_prev_next;
  logic [1:0]       prime_reg;
  logic [1:0]       prime_next;
  logic             primed;
  logic             ram_changed;

  // front panel request
  logic             pend_reg;
  logic             pend_next;

  // emitter control
  logic             ir_dis_n_reg;
  logic             ir_dis_n_next;

  // dump sequence
  fpks_state_t      state_reg;
  fpks_state_t      state_next;
  logic [RAM_W-1:0] snap_reg;
  logic [RAM_W-1:0] snap_next;
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;
  logic [7:0]       last_cmd_reg;
  logic [7:0]       last_cmd_next;

  // read data
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // bus decode
  logic             wr_cmd;
  logic             wr_ir;
  logic             wr_clr;
  logic             wr_en;
  logic             rd_data;
  logic             cmd_read;
  logic             cmd_clear;
  logic             cmd_bad;
  logic             dump_last;
  logic [7:0]       data_byte;

  // events
  logic [EVT_N-1:0] evt;
  logic [EVT_N-1:0] evt_status;
  logic [EVT_N-1:0] evt_enable;

  fpks_sync #(
    .W (KEY_N)
  ) u_key_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (RSTN_I),
    .d_i     (HARD_KEY_OPEN_I),
    .q_o     (key_sync)
  );

  fpks_sync #(
    .W (ROW_N)
  ) u_row_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (RSTN_I),
    .d_i     (ROW_UNSENSED_I),
    .q_o     (row_sync)
  );

  // key bit k sits at RAM bit k, row bit r at RAM bit 16+r; rest reads zero
  always_comb begin
    ram_live = '0;
    ram_live[KEY_POS +: KEY_N] = key_sync;
    ram_live[ROW_POS +: ROW_N] = row_sync;
  end

  // decode
  always_comb begin
    wr_cmd    = WR_I && (ADDR_I == OFS_CMD);
    wr_ir     = WR_I && (ADDR_I == OFS_IR_CTRL);
    wr_clr    = WR_I && (ADDR_I == OFS_CLEAR);
    wr_en     = WR_I && (ADDR_I == OFS_ENABLE);
    rd_data   = RD_I && (ADDR_I == OFS_DATA);
    cmd_read  = wr_cmd && (WDATA_I[7:0] == CMD_READ_RAM);
    cmd_clear = wr_cmd && (WDATA_I[7:0] == CMD_CLR_IRQ);
    cmd_bad   = wr_cmd && !cmd_read && !cmd_clear;
  end

  // change detection; sync chain plus previous image need three edges to
  // fill after reset, so comparing before then would fire a false change
  always_comb begin
    prime_next    = prime_reg;
    ram_prev_next = ram_live;
    primed        = (prime_reg == PRIME_CYC);
    if (!primed) begin
      prime_next = prime_reg + 2'h1;
    end
    ram_changed = primed && (ram_live != ram_prev_reg);
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prime_reg    <= '0;
      ram_prev_reg <= '0;
    end else begin
      prime_reg    <= prime_next;
      ram_prev_reg <= ram_prev_next;
    end
  end

  // pending request: set by change, held until clear command
  always_comb begin
    pend_next = pend_reg;
    if (cmd_clear) begin
      pend_next = 1'b0;
    end
    if (ram_changed) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  assign FRONT_PANEL_REQUEST_INPUT_O = pend_reg;

  // emitter control; other values leave the line alone
  always_comb begin
    ir_dis_n_next = ir_dis_n_reg;
    if (wr_ir && (WDATA_I[7:0] == IR_OFF_VAL)) begin
      ir_dis_n_next = 1'b0;
    end else if (wr_ir && (WDATA_I[7:0] == IR_ON_VAL)) begin
      ir_dis_n_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ir_dis_n_reg <= IR_DIS_N_RST;
    end else begin
      ir_dis_n_reg <= ir_dis_n_next;
    end
  end

  assign INFRARED_EMITTER_DISABLE_N_O = ir_dis_n_reg;

  // dump sequence: snapshot keeps the eight bytes coherent even while
  // sensors move during the reads
  always_comb begin
    dump_last = (ptr_reg == PTR_W'(RAM_BYTES - 1));
    data_byte = snap_reg[{ptr_reg[2:0], 3'b000} +: 8];
  end

  always_comb begin
    state_next    = state_reg;
    snap_next     = snap_reg;
    ptr_next      = ptr_reg;
    last_cmd_next = last_cmd_reg;
    if (wr_cmd) begin
      last_cmd_next = WDATA_I[7:0];
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (cmd_read) begin
          state_next = ST_DUMP;
          snap_next  = ram_live;
          ptr_next   = '0;
        end
      end
      ST_DUMP: begin
        if (cmd_read) begin
          snap_next = ram_live;
          ptr_next  = '0;
        end else if (rd_data) begin
          ptr_next = ptr_reg + PTR_W'(1);
          if (dump_last) begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg    <= ST_IDLE;
      snap_reg     <= '0;
      ptr_reg      <= '0;
      last_cmd_reg <= '0;
    end else begin
      state_reg    <= state_next;
      snap_reg     <= snap_next;
      ptr_reg      <= ptr_next;
      last_cmd_reg <= last_cmd_next;
    end
  end

  // events into the status block
  always_comb begin
    evt              = '0;
    evt[EVT_CHANGE]  = ram_changed;
    evt[EVT_DUMP]    = (state_reg == ST_DUMP) && rd_data && dump_last
                       && !cmd_read;
    evt[EVT_BAD_CMD] = cmd_bad;
  end

  fpks_evt u_evt (
    .clk_i    (MCLK_I),
    .rst_n_i  (RSTN_I),
    .evt_i    (evt),
    .clr_wr_i (wr_clr),
    .en_wr_i  (wr_en),
    .wdata_i  (WDATA_I[EVT_N-1:0]),
    .status_o (evt_status),
    .enable_o (evt_enable),
    .irq_o    (IRQ_O)
  );

  // read data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (RD_I) begin
      unique case (ADDR_I)
        OFS_CMD: begin
          rdata_next[7:0] = last_cmd_reg;
        end
        OFS_DATA: begin
          if (state_reg == ST_DUMP) begin
            rdata_next[7:0] = data_byte;
          end
        end
        OFS_IR_CTRL: begin
          rdata_next[0] = ir_dis_n_reg;
        end
        OFS_STATUS: begin
          rdata_next[EVT_N-1:0] = evt_status;
        end
        OFS_ENABLE: begin
          rdata_next[EVT_N-1:0] = evt_enable;
        end
        OFS_LIVE: begin
          rdata_next[KEY_N-1:0]          = key_sync;
          // only rows 0..15 fit beside the keys in one word
          rdata_next[ROW_POS +: 16]      = row_sync[15:0];
        end
        OFS_STATE: begin
          rdata_next[0]                  = pend_reg;
          rdata_next[1]                  = (state_reg == ST_DUMP);
          rdata_next[4 +: PTR_W]         = ptr_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA_O = rdata_reg;

endmodule // fpks_top

/* dv/fpks_props.sv */
module fpks_props
  import fpks_pkg::*;
(
  input wire logic              MCLK_I,
  input wire logic              RSTN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  input wire logic [KEY_N-1:0]  HARD_KEY_OPEN_I,
  input wire logic [ROW_N-1:0]  ROW_UNSENSED_I,
  input wire logic              INFRARED_EMITTER_DISABLE_N_O,
  input wire logic              FRONT_PANEL_REQUEST_INPUT_O
);
  logic [31:0] pins_reg;
  logic [3:0]  quiet_reg, quiet_next;
  logic [1:0]  age_reg, age_next;
  logic        clr_cmd, ir_wr;
  assign clr_cmd = WR_I && ADDR_I == OFS_CMD && WDATA_I[7:0] == CMD_CLR_IRQ;
  assign ir_wr   = WR_I && ADDR_I == OFS_IR_CTRL;
  // cycles since the last pin change; ignored until the design has armed
  always_comb begin
    age_next   = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
    quiet_next = (quiet_reg == 4'hF) ? quiet_reg : quiet_reg + 4'h1;
    if (age_reg == 2'h3 && {HARD_KEY_OPEN_I, ROW_UNSENSED_I} != pins_reg[31:0])
      quiet_next = 4'h0;
  end
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pins_reg  <= 32'h0000_0000;
      quiet_reg <= 4'hF;
      age_reg   <= 2'h0;
    end else begin
      pins_reg  <= {HARD_KEY_OPEN_I, ROW_UNSENSED_I};
      quiet_reg <= quiet_next;
      age_reg   <= age_next;
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  chk_rdata_idle: assert property (!RD_I |=> RDATA_O == '0)
    else $error("read data not zero outside a read answer");
  chk_ir_off: assert property (ir_wr && WDATA_I == 32'h0000_0000
    |=> !INFRARED_EMITTER_DISABLE_N_O)
    else $error("emitter line not low after off write");
  chk_ir_on: assert property (ir_wr && WDATA_I == 32'h0000_0001
    |=> INFRARED_EMITTER_DISABLE_N_O)
    else $error("emitter line not high after on write");
  chk_ir_hold: assert property (!ir_wr
    |=> $stable(INFRARED_EMITTER_DISABLE_N_O))
    else $error("emitter line moved without a write");
  chk_clr_req: assert property (clr_cmd && quiet_reg >= 4'h6
    |=> !FRONT_PANEL_REQUEST_INPUT_O)
    else $error("request not cleared by clear command");
  chk_req_hold: assert property (
    FRONT_PANEL_REQUEST_INPUT_O && !clr_cmd |=> FRONT_PANEL_REQUEST_INPUT_O)
    else $error("request dropped without clear command");
  chk_chg_req: assert property (quiet_reg == 4'h0
    |-> ##[1:6] FRONT_PANEL_REQUEST_INPUT_O)
    else $error("sensor change raised no request");
  chk_no_spurious: assert property (
    $rose(FRONT_PANEL_REQUEST_INPUT_O) |-> quiet_reg <= 4'h7)
    else $error("request rose without a sensor change");
endmodule // fpks_props

bind fpks_top fpks_props fpks_props_i (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .HARD_KEY_OPEN_I(HARD_KEY_OPEN_I), .ROW_UNSENSED_I(ROW_UNSENSED_I),
  .INFRARED_EMITTER_DISABLE_N_O(INFRARED_EMITTER_DISABLE_N_O),
  .FRONT_PANEL_REQUEST_INPUT_O(FRONT_PANEL_REQUEST_INPUT_O)
);

/* dv/fpks_host.sv */
module fpks_host
  import fpks_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic              req_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o,
  output logic                   wr_o,
  output logic                   rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // released data never looks like a held value
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(negedge clk_i);
    d = rdata_i;
  endtask
  task automatic dump(output logic [63:0] ram);
    logic [31:0] d;
    wr(OFS_CMD, {24'h00_0000, CMD_READ_RAM});
    for (int n = 0; n < 8; n++) begin
      rd(OFS_DATA, d);
      ram[8*n+:8] = d[7:0];
    end
  endtask
  // read, clear, wait, check; bounded so a stuck request cannot hang
  task automatic settle(output logic [63:0] ram, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      dump(ram);
      wr(OFS_CMD, {24'h00_0000, CMD_CLR_IRQ});
      repeat (8) @(posedge clk_i);
      ok = (req_i === 1'b0);
    end
  endtask
endmodule // fpks_host

/* dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import fpks_pkg::*;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [KEY_N-1:0]  keys = '1;
  logic [ROW_N-1:0]  pat = '0;
  logic [ROW_N-1:0]  rows = '1;
  logic [63:0]       ram;
  logic [31:0]       d;
  logic              ok;
  wire  [ADDR_W-1:0] addr;
  wire  [DATA_W-1:0] wdata, rdata;
  wire               wr, rd, line, req, irq;
  int                bad_count = 0;
  int                n_tests = 0;
  int                cyc = 0;
  always #12.5 clk = ~clk;
  // dark emitters leave every receptor unsensed
  always @(posedge clk) rows <= line ? pat : '1;
  fpks_top fpks_top_i (.MCLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .HARD_KEY_OPEN_I(keys), .ROW_UNSENSED_I(rows),
    .INFRARED_EMITTER_DISABLE_N_O(line),
    .FRONT_PANEL_REQUEST_INPUT_O(req), .IRQ_O(irq));
  fpks_host fpks_host_i (.clk_i(clk), .rdata_i(rdata), .req_i(req),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(99794));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("req", req, 0);
    chk("irq", irq, 0);
    fpks_host_i.wr(OFS_IR_CTRL, 32'h0000_0000);
    @(negedge clk) chk("line", line, 0);
    fpks_host_i.wr(OFS_IR_CTRL, 32'h0000_0002);
    @(negedge clk) chk("line", line, 0);
    fpks_host_i.wr(OFS_IR_CTRL, 32'h0000_0001);
    @(negedge clk) chk("line", line, 1);
    fpks_host_i.wr(OFS_ENABLE, 32'h0000_0001);
    for (int t = 0; t < 14; t++) begin
      @(posedge clk);
      keys <= (t < 10) ? ~(10'h001 << t) : KEY_N'($urandom);
      pat  <= ROW_N'($urandom);
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk("req", req, 1);
      chk("irq", irq, 1);
      fpks_host_i.settle(ram, ok);
      chk("settle", ok, 1);
      chk("keys", ram[31:0], {rows[15:0], 6'h0, keys});
      chk("rows", ram[63:32], {26'h0, rows[21:16]});
      fpks_host_i.rd(OFS_DATA, d);
      chk("ninth", d, 0);
    end
    fpks_host_i.wr(OFS_CLEAR, 32'h0000_0007);
    @(negedge clk) chk("irq", irq, 0);
    fpks_host_i.wr(OFS_ENABLE, 32'h0000_0000);
    pat <= ~pat;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("masked", irq, 0);
    chk("req", req, 1);
    fpks_host_i.rd(OFS_STATUS, d);
    chk("status", d[0], 1);
    fpks_host_i.wr(OFS_CMD, {24'h00_0000, CMD_CLR_IRQ});
    @(negedge clk) chk("req", req, 0);
    fpks_host_i.rd(8'h40, d);
    chk("unmapped", d, 0);
    report_and_stop();
  end
endmodule // testbench
